/* File: src/sarc_pkg.sv */
// Purpose: Shared constants and types for the converter link ends
// Assumes: hclk runs at 100 MHz
// Notes:   Conversion and wake times are kept in ns and turned into cycle counts here
package sarc_pkg;
    // ----------------------------------------
    // Word and timing
    // ----------------------------------------
    localparam int RES_BITS   = 14;
    localparam int CHAIN_DLY  = 14;
    localparam int CLK_NS     = 10;
    localparam int CONV_NS    = 300;
    localparam int WAKE_NS    = 100;
    localparam int CONV_CYC   = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC   = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC  = 6;
    localparam int HOLD_CYC   = 6;
    localparam int SETTLE_CYC = 8;
    localparam int SCK_HALF   = 8;
    localparam int WAIT_CYC   = CONV_CYC + WAKE_CYC + 16;
    localparam logic [15:0] CONV_LAST   = 16'(CONV_CYC - 1);
    localparam logic [15:0] WAKE_LAST   = 16'(WAKE_CYC - 1);
    localparam logic [15:0] SETUP_LAST  = 16'(SETUP_CYC - 1);
    localparam logic [15:0] HOLD_LAST   = 16'(HOLD_CYC - 1);
    localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);
    localparam logic [15:0] HALF_LAST   = 16'(SCK_HALF - 1);
    localparam logic [15:0] WAIT_LAST   = 16'(WAIT_CYC - 1);
    // ----------------------------------------
    // Host register map
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam int CTRL_START  = 0;
    localparam int CTRL_CHAIN  = 1;
    localparam int CTRL_FAST   = 2;
    localparam int CTRL_REFPD  = 3;
    localparam int CTRL_REFBUF = 4;
    localparam int CTRL_BUSY   = 5;
    localparam int CTRL_W      = 6;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_VALID  = 1;
    localparam int STAT_DISC   = 2;
    // ----------------------------------------
    // State machines
    // ----------------------------------------
    typedef enum logic [1:0] {
        DS_IDLE = 2'h0, DS_WAKE = 2'h1, DS_CONV = 2'h3
    } sarc_dev_state_e;
    typedef enum logic [2:0] {
        HS_IDLE = 3'h0, HS_SETUP = 3'h1, HS_CONV = 3'h3,
        HS_SETTLE = 3'h2, HS_SHIFT = 3'h6, HS_FINISH = 3'h7
    } sarc_host_state_e;
endpackage

/* File: src/sarc_if.sv */
// Purpose: Pins between the converter end and the host end
// Assumes: sck is made by the host and stands still outside frames
// Notes:   Output enable is separate; the bench resolves the wire
interface sarc_if;
    logic convert_start;
    logic sck;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_out_oe;
    logic fast_mode;
    logic ref_powerdown;
    logic ref_buffer_input;
    modport dev (
        input  convert_start, sck, serial_data_in,
        input  fast_mode, ref_powerdown, ref_buffer_input,
        output serial_data_out, serial_data_out_oe
    );
    modport host (
        output convert_start, sck, serial_data_in,
        output fast_mode, ref_powerdown, ref_buffer_input,
        input  serial_data_out, serial_data_out_oe
    );
endinterface

/* File: src/sarc_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous levels
// Notes:   Output follows once stages two and three agree
module sarc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                q[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
                q[i] <= s3_r[i];
            end
        end
    end
endmodule

/* File: src/sarc_dev.sv */
// Purpose: Converter end: conversion control and serial readout
// Assumes: hclk is the internal conversion clock; sck comes from the host
// Notes:   Readout logic runs on sck and is cleared while converting
//
// Notes on behaviour
// - Convert-start rising edge begins a conversion
// - Data input low at edge: chain mode
// - Data input high at edge: select mode
// - Select mode drives output while start low
// - Chain mode: host reads with start high
// - Chain: input reappears 14 clocks later
// - Select mode: output on if either low
// - Select mode: either low at completion arms busy flag
// - Host clocks; result shifts out on sck
// - Fast mode stays powered, 2.5 MSPS
// - Normal mode powers down, 2.0 MSPS
// - Reference down input disables internal reference
// - Down and input grounded: buffer, bandgap off
// - Host flags first result after fast entry for discard
// - Conversion timed by internal clock only
module sarc_dev (
    // Conversion clock and reset
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    // Link
    sarc_if.dev                                lnk,
    // Analog side
    input  wire logic [sarc_pkg::RES_BITS-1:0] sample_code,
    output logic                               converting,
    output logic                               core_powered,
    output logic                               ref_int_en,
    output logic                               ref_buf_en,
    output logic                               bandgap_en
);
    import sarc_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0]            pins_q;
    logic                  cnv_q;
    logic                  sdi_q;
    logic                  fast_q;
    logic                  refpd_q;
    logic                  refbuf_q;
    logic                  cnv_prev_r;
    logic                  cnv_rise;

    sarc_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({lnk.convert_start, lnk.serial_data_in, lnk.fast_mode,
                 lnk.ref_powerdown, lnk.ref_buffer_input}),
        .q     (pins_q)
    );

    assign cnv_q    = pins_q[4];
    assign sdi_q    = pins_q[3];
    assign fast_q   = pins_q[2];
    assign refpd_q  = pins_q[1];
    assign refbuf_q = pins_q[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnv_prev_r <= 1'b0;
        end else begin
            cnv_prev_r <= cnv_q;
        end
    end

    assign cnv_rise = cnv_q & ~cnv_prev_r;

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    sarc_dev_state_e       state_r;
    logic [15:0]           cnt_r;
    logic                  done;
    logic                  cs_mode_r;
    logic                  busy_ind_r;
    logic [RES_BITS-1:0]   sample_r;
    logic [RES_BITS-1:0]   result_r;

    assign done = (state_r == DS_CONV) && (cnt_r == CONV_LAST);

    // Edges arriving mid-conversion are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= DS_IDLE;
        end else begin
            case (state_r)
                DS_IDLE: begin
                    if (cnv_rise) begin
                        state_r <= fast_q ? DS_CONV : DS_WAKE;
                    end
                end
                DS_WAKE: begin
                    if (cnt_r == WAKE_LAST) begin
                        state_r <= DS_CONV;
                    end
                end
                DS_CONV: begin
                    if (done) begin
                        state_r <= DS_IDLE;
                    end
                end
                default: begin
                    state_r <= DS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
        end else if (state_r == DS_IDLE || done || cnt_r == WAKE_LAST
                     && state_r == DS_WAKE) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_mode_r <= 1'b1;
            sample_r  <= '0;
        end else if (state_r == DS_IDLE && cnv_rise) begin
            cs_mode_r <= sdi_q;
            sample_r  <= sample_code;
        end
    end

    // No pipeline: the result lands as the conversion ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_r <= '0;
        end else if (done) begin
            result_r <= sample_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_ind_r <= 1'b0;
        end else if (state_r == DS_IDLE && cnv_rise) begin
            busy_ind_r <= 1'b0;
        end else if (done) begin
            busy_ind_r <= cs_mode_r & (~sdi_q | ~cnv_q);
        end
    end

    // ----------------------------------------
    // Power and reference control
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            converting   <= 1'b0;
            core_powered <= 1'b0;
        end else begin
            converting   <= (state_r != DS_IDLE) || (state_r == DS_IDLE && cnv_rise);
            // Powers up on the start edge, in step with converting
            core_powered <= fast_q || (state_r != DS_IDLE) || cnv_rise;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_int_en <= 1'b1;
            ref_buf_en <= 1'b1;
            bandgap_en <= 1'b1;
        end else begin
            ref_int_en <= ~refpd_q;
            ref_buf_en <= ~(refpd_q & ~refbuf_q);
            bandgap_en <= ~(refpd_q & ~refbuf_q);
        end
    end

    // ----------------------------------------
    // Output enable
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lnk.serial_data_out_oe <= 1'b0;
        end else if (cs_mode_r) begin
            lnk.serial_data_out_oe <= ~sdi_q | ~cnv_q;
        end else begin
            lnk.serial_data_out_oe <= cnv_q & (state_r == DS_IDLE);
        end
    end

    // ----------------------------------------
    // Serial shifter on sck
    // ----------------------------------------
    // result_r and busy_ind_r only move while converting, when sck stands still
    logic                  frame_clr;
    logic                  ld_r;
    logic [RES_BITS:0]     sh_r;
    logic [RES_BITS:0]     pre;
    logic [RES_BITS:0]     cur;

    assign frame_clr = ~hresetn | converting;

    always_comb begin
        pre = busy_ind_r ? {1'b1, result_r} : {result_r, 1'b0};
        cur = ld_r ? sh_r : pre;
    end

    always_ff @(posedge lnk.sck or posedge frame_clr) begin
        if (frame_clr) begin
            ld_r <= 1'b0;
        end else begin
            ld_r <= 1'b1;
        end
    end

    // Input enters at bit one so it leaves CHAIN_DLY clocks later
    always_ff @(posedge lnk.sck or negedge hresetn) begin
        if (!hresetn) begin
            sh_r <= '0;
        end else if (busy_ind_r) begin
            sh_r <= {cur[RES_BITS-1:0], lnk.serial_data_in};
        end else begin
            sh_r <= {cur[RES_BITS-1:1], lnk.serial_data_in, 1'b0};
        end
    end

    // Driven low while busy so an armed busy flag shows the rising edge
    assign lnk.serial_data_out = converting ? 1'b0 : cur[RES_BITS];

endmodule

/* File: src/sarc_host.sv */
// Purpose: Host end: AHB-Lite registers driving convert and readout
// Assumes: Single slave; sck is divided from hclk
// Notes:   Reads only the nearest converter of a chain
module sarc_host (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Link
    sarc_if.host             lnk
);
    import sarc_pkg::*;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic                  acc;
    logic                  wr_pend_r;
    logic [7:0]            wr_addr_r;
    logic [CTRL_W-1:0]     ctrl_r;
    logic                  start;
    logic                  valid_r;
    logic                  disc_r;
    logic                  first_pend_r;
    logic [RES_BITS-1:0]   data_r;
    sarc_host_state_e      state_r;
    logic                  fin;
    logic                  data_rd;

    // hsize ignored: only whole words are supported
    assign acc     = hsel & htrans[1] & hready;
    assign start   = wr_pend_r && wr_addr_r == REG_CTRL && hwdata[CTRL_START];
    assign fin     = state_r == HS_FINISH;
    assign data_rd = acc && !hwrite && haddr[7:0] == REG_DATA;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= acc & hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (acc && !hwrite) begin
            if (haddr[7:0] == REG_CTRL) begin
                hrdata <= {{(32-CTRL_W){1'b0}}, ctrl_r};
            end else if (haddr[7:0] == REG_STAT) begin
                hrdata <= {29'h0, disc_r, valid_r, state_r != HS_IDLE};
            end else if (haddr[7:0] == REG_DATA) begin
                hrdata <= {{(32-RES_BITS){1'b0}}, data_r};
            end else begin
                hrdata <= '0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Buffer input starts high so the pin keeps its reset level
            ctrl_r <= CTRL_W'(1) << CTRL_REFBUF;
        end else if (wr_pend_r && wr_addr_r == REG_CTRL) begin
            ctrl_r <= hwdata[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_START);
        end
    end

    // Completion wins over a same-cycle read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valid_r <= 1'b0;
        end else if (fin) begin
            valid_r <= 1'b1;
        end else if (data_rd) begin
            valid_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_pend_r <= 1'b0;
        end else if (wr_pend_r && wr_addr_r == REG_CTRL
                     && hwdata[CTRL_FAST] && !ctrl_r[CTRL_FAST]) begin
            first_pend_r <= 1'b1;
        end else if (fin) begin
            first_pend_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Link sequencer
    // ----------------------------------------
    logic                  sdo_q;
    logic [15:0]           tmr_r;
    logic [4:0]            bit_r;
    logic [RES_BITS:0]     shin_r;
    logic                  chain_r;
    logic                  busy_en_r;
    logic [4:0]            last_bit;

    sarc_sync #(
        .WIDTH (1)
    ) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (lnk.serial_data_out),
        .q     (sdo_q)
    );

    assign last_bit = busy_en_r ? 5'(RES_BITS) : 5'(RES_BITS - 1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r   <= HS_IDLE;
            tmr_r     <= '0;
            bit_r     <= '0;
            shin_r    <= '0;
            chain_r   <= 1'b0;
            busy_en_r <= 1'b0;
            lnk.convert_start  <= 1'b0;
            lnk.serial_data_in <= 1'b1;
            lnk.sck            <= 1'b0;
        end else begin
            tmr_r <= tmr_r + 16'h0001;
            case (state_r)
                HS_IDLE: begin
                    tmr_r <= '0;
                    if (start) begin
                        chain_r   <= hwdata[CTRL_CHAIN];
                        busy_en_r <= ~hwdata[CTRL_CHAIN] & hwdata[CTRL_BUSY];
                        lnk.serial_data_in <= ~hwdata[CTRL_CHAIN];
                        state_r   <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    if (tmr_r == SETUP_LAST) begin
                        lnk.convert_start <= 1'b1;
                        tmr_r   <= '0;
                        state_r <= HS_CONV;
                    end
                end
                HS_CONV: begin
                    if (tmr_r == HOLD_LAST && busy_en_r) begin
                        lnk.serial_data_in <= 1'b0;
                    end
                    if (tmr_r == WAIT_LAST) begin
                        lnk.convert_start  <= chain_r;
                        lnk.serial_data_in <= ~busy_en_r & ~chain_r;
                        tmr_r   <= '0;
                        state_r <= HS_SETTLE;
                    end
                end
                HS_SETTLE: begin
                    if (tmr_r == SETTLE_LAST) begin
                        tmr_r   <= '0;
                        bit_r   <= '0;
                        state_r <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    if (tmr_r == HALF_LAST) begin
                        tmr_r <= '0;
                        if (!lnk.sck) begin
                            shin_r  <= {shin_r[RES_BITS-1:0], sdo_q};
                            lnk.sck <= 1'b1;
                        end else begin
                            lnk.sck <= 1'b0;
                            bit_r   <= bit_r + 5'h01;
                            if (bit_r == last_bit) begin
                                state_r <= HS_FINISH;
                            end
                        end
                    end
                end
                HS_FINISH: begin
                    lnk.convert_start  <= 1'b0;
                    lnk.serial_data_in <= 1'b1;
                    state_r <= HS_IDLE;
                end
                default: begin
                    state_r <= HS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_r <= '0;
            disc_r <= 1'b0;
        end else if (fin) begin
            data_r <= shin_r[RES_BITS-1:0];
            disc_r <= first_pend_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lnk.fast_mode        <= 1'b0;
            lnk.ref_powerdown    <= 1'b0;
            lnk.ref_buffer_input <= 1'b1;
        end else begin
            lnk.fast_mode        <= ctrl_r[CTRL_FAST];
            lnk.ref_powerdown    <= ctrl_r[CTRL_REFPD];
            lnk.ref_buffer_input <= ctrl_r[CTRL_REFBUF];
        end
    end
endmodule

/* File: verification/sarc_props.sv */
// Purpose: Concurrent checks on the link pins between the two ends
// Assumes: Sampled on hclk; sck is a host flop on hclk
// Notes:   Mode is tracked from the start edge, not read from either end
module sarc_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link pins
    input wire logic convert_start,
    input wire logic sck,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       sel_mode_r;
    logic       cnv_q_r;
    logic       sck_q_r;
    logic [4:0] rise_cnt_r;
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_mode_r <= 1'b0;
            cnv_q_r    <= 1'b0;
            sck_q_r    <= 1'b0;
        end else begin
            cnv_q_r <= convert_start;
            sck_q_r <= sck;
            if (convert_start && !cnv_q_r) begin
                sel_mode_r <= serial_data_in;
            end
        end
    end
    // Saturates so a runaway frame cannot wrap back to a legal count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_cnt_r <= 5'h00;
        end else if (convert_start && !cnv_q_r) begin
            rise_cnt_r <= 5'h00;
        end else if (sck && !sck_q_r && rise_cnt_r != 5'h1F) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    start_mode_a: assert property (
        $rose(convert_start) |-> $stable(serial_data_in)) else $error("mode pin moved at start");
    conv_quiet_a: assert property (
        $rose(convert_start) |=> !sck [*8]) else $error("sck ran during conversion");
    // Eight cycles cover the pin filter and the enable flop
    sel_drive_a: assert property (
        (sel_mode_r && (!convert_start || !serial_data_in)) [*8] |-> serial_data_out_oe)
        else $error("output not enabled in select mode");
    sel_quiet_a: assert property (
        (sel_mode_r && convert_start && serial_data_in) [*8] |-> !serial_data_out_oe)
        else $error("output enabled while deselected");
    shift_hold_a: assert property (
        $past(sck) |-> $stable(serial_data_out)) else $error("data moved off sck rise");
    sck_gate_a: assert property (
        sck |-> (sel_mode_r ? !convert_start : convert_start))
        else $error("sck outside a frame");
    sck_half_a: assert property (
        $rose(sck) |-> sck [*8] ##1 !sck) else $error("sck high phase wrong");
    frame_len_a: assert property (
        $fell(convert_start) |-> (sel_mode_r ? rise_cnt_r == 5'h00 : rise_cnt_r == 5'h0E))
        else $error("wrong sck count in frame");
endmodule

/* File: verification/tb.sv */
// Purpose: Bench for the host and converter ends joined by the link
// Assumes: hclk 100 MHz; sck comes from the host divider
// Notes:   Only the nearest converter is read back
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sarc_pkg::*;
    logic                hclk = 1'b0;
    logic                hresetn = 1'b0;
    logic                hsel = 1'b0;
    logic [31:0]         haddr = 32'h0;
    logic [1:0]          htrans = 2'h0;
    logic                hwrite = 1'b0;
    logic [31:0]         hwdata = 32'h0;
    logic [RES_BITS-1:0] code = 14'h0;
    logic [31:0]         hrdata;
    logic [31:0]         rd;
    logic                hreadyout, hresp, conv, cpow, rint, rbuf, bgap;
    int                  miscompares = 0;
    int                  checks_done = 0;
    wire sdo_w = sarc_if_inst.serial_data_out_oe ? sarc_if_inst.serial_data_out : 1'bz;
    always #5 hclk = ~hclk;
    // ----------------------------------------
    // Ends, link and checker
    // ----------------------------------------
    sarc_if sarc_if_inst ();
    sarc_dev sarc_dev_inst (.hclk(hclk), .hresetn(hresetn), .lnk(sarc_if_inst.dev),
        .sample_code(code), .converting(conv), .core_powered(cpow), .ref_int_en(rint),
        .ref_buf_en(rbuf), .bandgap_en(bgap));
    sarc_host sarc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lnk(sarc_if_inst.host));
    sarc_props sarc_props_inst (.hclk(hclk), .hresetn(hresetn),
        .convert_start(sarc_if_inst.convert_start), .sck(sarc_if_inst.sck),
        .serial_data_in(sarc_if_inst.serial_data_in),
        .serial_data_out(sarc_if_inst.serial_data_out),
        .serial_data_out_oe(sarc_if_inst.serial_data_out_oe));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic t_idle();
        chk({31'h0, sdo_w}, 32'h0);
        ahb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h10);
        ahb(1'b1, 8'h0C, 32'hFFFF);
        ahb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, REG_STAT, 32'h0);
        chk(rd, 32'h0);
        $display("test idle done");
    endtask
    task automatic t_conv(input logic [5:0] ctl, input logic [13:0] c, input logic disc);
        int n;
        code <= c;
        ahb(1'b1, REG_CTRL, {26'h0, ctl});
        n = 0;
        while (conv !== 1'b1 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, conv}, 32'h1);
        if (!ctl[CTRL_CHAIN] && !ctl[CTRL_BUSY]) begin
            chk({31'h0, sdo_w}, {31'h0, 1'bz});
        end
        chk({31'h0, cpow}, 32'h1);
        n = 0;
        do begin
            ahb(1'b0, REG_STAT, 32'h0);
            n++;
        end while (rd[STAT_VALID] !== 1'b1 && n < 300);
        chk(rd & 32'h7, {29'h0, disc, 2'b10});
        ahb(1'b0, REG_DATA, 32'h0);
        chk(rd, {18'h0, c});
        ahb(1'b0, REG_STAT, 32'h0);
        chk(rd & 32'h2, 32'h0);
        chk({31'h0, conv}, 32'h0);
        $display("test conv %h done", ctl);
    endtask
    task automatic t_ref();
        logic [2:0] i;
        for (int k = 0; k < 8; k++) begin
            i = 3'(k);
            ahb(1'b1, REG_CTRL, {27'h0, i[1], i[0], i[2], 2'b00});
            // Pin filters need about four cycles
            repeat (8) @(posedge hclk);
            chk({29'h0, rint, rbuf, bgap}, {29'h0, !i[0], {2{!(i[0] && !i[1])}}});
            chk({31'h0, cpow}, {31'h0, i[2]});
        end
        $display("test ref done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        t_idle();
        t_conv(6'h01, 14'h2AAA, 1'b0);
        t_conv(6'h05, 14'h3FFF, 1'b1);
        t_conv(6'h05, 14'h0001, 1'b0);
        t_conv(6'h03, 14'h2000, 1'b0);
        t_conv(6'h21, 14'h1555, 1'b0);
        t_ref();
        conclude();
    end
    // Runs about six times the expected length
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule
